//--- logic/fsc_map.svh
// Register indices, field positions and reset values of the flash control.
// Operation
// - Reset copies nonvolatile protect and option bytes.
// - Enabled backdoor key unlocks on 8-byte match.
// - Key writes only from secure code, never debug.
// - Disabled key: only erase plus blank unsecures.
// - Security code 1:0 means unsecured, else secured.
// - Registers decoded in high page from 0x1800.
// - Compare eight key bytes in ascending order.
// - Successful unlock sets security code to 1:0.
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
`define FSC_HIGH_PAGE_BASE  14'h1800
`define FSC_IDX_CLKDIV      14'h1820
`define FSC_IDX_OPTION      14'h1821
`define FSC_IDX_CONFIG      14'h1823
`define FSC_IDX_PROTECT     14'h1824
`define FSC_IDX_STATUS      14'h1825
`define FSC_IDX_COMMAND     14'h1826
`define FSC_IDX_KEY_DATA    14'h1830
`define FSC_IDX_IRQ_STATUS  14'h1831
`define FSC_IDX_IRQ_MASK    14'h1832
`define FSC_DIV_LOADED_BIT  7
`define FSC_PRESCALE_BIT    6
`define FSC_KEY_ENABLE_BIT  7
`define FSC_NO_REDIRECT_BIT 6
`define FSC_KEY_ACCESS_BIT  5
`define FSC_ST_READY_BIT    7
`define FSC_ST_DONE_BIT     6
`define FSC_ST_VIOLATE_BIT  5
`define FSC_ST_ACC_ERR_BIT  4
`define FSC_ST_BLANK_BIT    2
`define FSC_IRQ_UNLOCK_BIT  0
`define FSC_IRQ_MISMATCH_BIT 1
`define FSC_IRQ_BLANK_BIT   2
`define FSC_IRQ_ACCERR_BIT  3
`define FSC_UNSECURED_CODE  2'b10
`define FSC_PRESCALE_MAX    3'h7
`define FSC_KEY_LAST        3'h7
`define FSC_RESET_BYTE      8'hff
`define FSC_ZERO_BYTE       8'h00
`endif

//--- logic/fsc_pkg.sv
// Types shared by the flash security and clock control.
package fsc_pkg;
    typedef enum logic [2:0] {
        FSC_KEY_IDLE    = 3'b001,
        FSC_KEY_COLLECT = 3'b010,
        FSC_KEY_DONE    = 3'b100
    } fsc_key_state_type;
    typedef logic [7:0] fsc_byte_type;
endpackage : fsc_pkg

//--- logic/fsc_top.sv
// Flash security, option load and timing clock control behind APB.
`timescale 1ns/1ps
`include "fsc_map.svh"
module fsc_top #(
    parameter int ADDR_W = 16
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire fsc_pkg::fsc_byte_type nv_protect_byte,
    input  wire fsc_pkg::fsc_byte_type nv_option_byte,
    input  wire logic [63:0]         stored_unlock_key,
    input  wire logic                from_secure_code,
    input  wire logic                debug_access,
    input  wire logic                mass_erase_done,
    input  wire logic                blank_verify_ok,
    output logic                     irq,
    output logic                     mem_secured,
    output logic                     fclk_tick,
    output fsc_pkg::fsc_byte_type    protect_working
);
    import fsc_pkg::*;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    fsc_byte_type      clock_divider_reg;
    fsc_byte_type      option_working_reg;
    fsc_byte_type      flash_config_reg;
    fsc_byte_type      flash_command_reg;
    logic [3:0]        irq_status;
    logic [3:0]        irq_mask;
    logic              acc_err;
    logic              acc_err_q;
    logic              blank_seen;
    logic              load_pending;
    logic              erased;
    fsc_key_state_type key_state;
    logic [2:0]        key_cnt;
    logic              key_bad;
    logic              key_ok_pulse;
    logic              key_bad_pulse;
    logic              blank_unsec;
    logic [2:0]        pre_cnt;
    logic [5:0]        div_cnt;

    // Word index of the access; the low two address bits must be zero.
    logic [13:0] idx;
    logic        aligned;
    logic        acc;
    logic        wr;
    logic        in_page;
    assign idx     = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign acc     = psel && penable && pready;
    assign wr      = acc && pwrite;
    // Only the flash control set of the high page answers here.
    assign in_page = (idx >= `FSC_HIGH_PAGE_BASE);

    logic backdoor_key_enable;
    logic key_write_access;
    logic prescale_by_eight;
    assign backdoor_key_enable = option_working_reg[`FSC_KEY_ENABLE_BIT];
    assign key_write_access    = flash_config_reg[`FSC_KEY_ACCESS_BIT];
    assign prescale_by_eight   = clock_divider_reg[`FSC_PRESCALE_BIT];

    // A key byte counts only from secure user code with the path enabled.
    logic key_wr_req;
    logic key_wr;
    assign key_wr_req = wr && aligned && (idx == `FSC_IDX_KEY_DATA);
    assign key_wr     = key_wr_req && backdoor_key_enable
                        && key_write_access && from_secure_code
                        && !debug_access;

    // Decode into a read value and an error flag.
    logic [31:0] next_prdata;
    logic        next_err;
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_err    = 1'b0;
        if (!aligned || !in_page)
            next_err = 1'b1;
        else if (idx == `FSC_IDX_CLKDIV)
            next_prdata[7:0] = clock_divider_reg;
        else if (idx == `FSC_IDX_OPTION)
            next_prdata[7:0] = option_working_reg;
        else if (idx == `FSC_IDX_CONFIG)
            next_prdata[7:0] = flash_config_reg;
        else if (idx == `FSC_IDX_PROTECT)
            next_prdata[7:0] = protect_working;
        else if (idx == `FSC_IDX_STATUS)
        begin
            next_prdata[`FSC_ST_READY_BIT]   = 1'b1;
            next_prdata[`FSC_ST_DONE_BIT]    = 1'b1;
            next_prdata[`FSC_ST_ACC_ERR_BIT] = acc_err;
            next_prdata[`FSC_ST_BLANK_BIT]  = blank_seen;
        end
        else if (idx == `FSC_IDX_COMMAND)
            next_prdata[7:0] = flash_command_reg;
        else if (idx == `FSC_IDX_KEY_DATA)
            next_prdata[7:0] = `FSC_ZERO_BYTE;
        else if (idx == `FSC_IDX_IRQ_STATUS)
            next_prdata[3:0] = irq_status;
        else if (idx == `FSC_IDX_IRQ_MASK)
            next_prdata[3:0] = irq_mask;
        else
            next_err = 1'b1;
    end

    // Zero-wait slave: pready rises in the first access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (psel && !penable && !pwrite)
                prdata <= next_prdata;
        end
    end

    // Working copies are loaded on the first edge after reset release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            load_pending <= 1'b1;
        else
            load_pending <= 1'b0;
    end

    // The protect byte is loaded at reset and writable afterwards.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            protect_working <= `FSC_RESET_BYTE;
        else if (load_pending)
            protect_working <= nv_protect_byte;
        else if (wr && aligned && idx == `FSC_IDX_PROTECT)
            protect_working <= pwdata[7:0];
    end

    // Option byte is read only; hardware alone moves the security code.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            option_working_reg <= `FSC_RESET_BYTE;
        else if (load_pending)
        begin
            option_working_reg       <= nv_option_byte;
            option_working_reg[5:2]  <= 4'h0;
        end
        else if (key_ok_pulse || blank_unsec)
            option_working_reg[1:0] <= `FSC_UNSECURED_CODE;
    end

    // Security follows the working code; secured until proven otherwise.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_secured <= 1'b1;
        else
            mem_secured <= (option_working_reg[1:0]
                            != `FSC_UNSECURED_CODE);
    end

    // Divider, config and command registers written by software.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_divider_reg <= `FSC_ZERO_BYTE;
            flash_config_reg  <= `FSC_ZERO_BYTE;
            flash_command_reg <= `FSC_ZERO_BYTE;
        end
        else if (wr && aligned)
        begin
            if (idx == `FSC_IDX_CLKDIV)
                clock_divider_reg <= {1'b1, pwdata[6:0]};
            else if (idx == `FSC_IDX_CONFIG)
                flash_config_reg <= {2'b00, pwdata[`FSC_KEY_ACCESS_BIT], 5'h00};
            else if (idx == `FSC_IDX_COMMAND)
                flash_command_reg <= pwdata[7:0];
        end
    end

    // A command before the divider is loaded is an access error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_err    <= 1'b0;
            acc_err_q  <= 1'b0;
            blank_seen <= 1'b0;
        end
        else
        begin
            // Delayed copy lets the event fire on the rising edge only.
            acc_err_q <= acc_err;
            if (wr && aligned && idx == `FSC_IDX_COMMAND
                && !clock_divider_reg[`FSC_DIV_LOADED_BIT])
                acc_err <= 1'b1;
            else if (wr && aligned && idx == `FSC_IDX_STATUS
                     && pwdata[`FSC_ST_ACC_ERR_BIT])
                acc_err <= 1'b0;
            if (blank_verify_ok)
                blank_seen <= 1'b1;
            else if (mass_erase_done)
                blank_seen <= 1'b0;
        end
    end

    // Blank check only unsecures after a full mass erase.
    assign blank_unsec = blank_verify_ok && erased;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            erased <= 1'b0;
        else if (mass_erase_done)
            erased <= 1'b1;
        else if (wr && aligned && idx == `FSC_IDX_COMMAND)
            erased <= 1'b0;
    end

    // Key bytes are compared in ascending order; one bad byte spoils all.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            key_state     <= FSC_KEY_IDLE;
            key_cnt       <= 3'h0;
            key_bad       <= 1'b0;
            key_ok_pulse  <= 1'b0;
            key_bad_pulse <= 1'b0;
        end
        else
        begin
            key_ok_pulse  <= 1'b0;
            key_bad_pulse <= 1'b0;
            case (key_state)
                FSC_KEY_IDLE:
                begin
                    key_cnt <= 3'h0;
                    key_bad <= 1'b0;
                    if (key_wr)
                    begin
                        key_bad   <= pwdata[7:0]
                                     != stored_unlock_key[7:0];
                        key_cnt   <= 3'h1;
                        key_state <= FSC_KEY_COLLECT;
                    end
                end
                FSC_KEY_COLLECT:
                begin
                    if (!key_write_access)
                        key_state <= FSC_KEY_IDLE;
                    else if (key_wr)
                    begin
                        if (pwdata[7:0] != stored_unlock_key[key_cnt*8 +: 8])
                            key_bad <= 1'b1;
                        key_cnt <= key_cnt + 3'h1;
                        if (key_cnt == `FSC_KEY_LAST)
                            key_state <= FSC_KEY_DONE;
                    end
                end
                FSC_KEY_DONE:
                begin
                    key_ok_pulse  <= !key_bad;
                    key_bad_pulse <= key_bad;
                    key_state     <= FSC_KEY_IDLE;
                end
                default:
                    key_state <= FSC_KEY_IDLE;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one clear.
    logic [3:0] events;
    assign events = {acc_err && !acc_err_q, blank_unsec,
                     key_bad_pulse, key_ok_pulse};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= 4'h0;
            irq_mask   <= 4'h0;
            irq        <= 1'b0;
        end
        else
        begin
            if (wr && aligned && idx == `FSC_IDX_IRQ_STATUS)
                irq_status <= (irq_status & ~pwdata[3:0]) | events;
            else
                irq_status <= irq_status | events;
            if (wr && aligned && idx == `FSC_IDX_IRQ_MASK)
                irq_mask <= pwdata[3:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // Timing clock: prescale by 8 or 1, then divide by divisor plus one.
    logic pre_tick;
    assign pre_tick = !prescale_by_eight
                      || (pre_cnt == `FSC_PRESCALE_MAX);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_cnt   <= 3'h0;
            div_cnt   <= 6'h00;
            fclk_tick <= 1'b0;
        end
        else if (wr && aligned && idx == `FSC_IDX_CLKDIV)
        begin
            pre_cnt   <= 3'h0;
            div_cnt   <= 6'h00;
            fclk_tick <= 1'b0;
        end
        else
        begin
            fclk_tick <= 1'b0;
            if (clock_divider_reg[`FSC_DIV_LOADED_BIT])
            begin
                pre_cnt <= pre_tick ? 3'h0 : pre_cnt + 3'h1;
                if (pre_tick)
                begin
                    if (div_cnt == clock_divider_reg[5:0])
                    begin
                        div_cnt   <= 6'h00;
                        fclk_tick <= 1'b1;
                    end
                    else
                        div_cnt <= div_cnt + 6'h01;
                end
            end
        end
    end

    // Helper: cycle gap between ticks and whether the divider held still.
    logic [9:0] gap;
    logic       clean;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap   <= 10'h000;
            clean <= 1'b0;
        end
        else
        begin
            gap <= fclk_tick ? 10'h001 : gap + 10'h001;
            if (wr && aligned && idx == `FSC_IDX_CLKDIV)
                clean <= 1'b0;
            else if (fclk_tick)
                clean <= 1'b1;
        end
    end
    logic [9:0] period;
    assign period = (prescale_by_eight ? 10'h008 : 10'h001)
                    * ({4'h0, clock_divider_reg[5:0]} + 10'h001);

    sequence s_setup_low;
        psel && !penable && !in_page;
    endsequence
    sequence s_key_finish_ok;
        key_state == FSC_KEY_DONE && !key_bad;
    endsequence

    AST_RESET_LOAD: assert property ($fell(load_pending) |->
        protect_working == $past(nv_protect_byte))
        else $error("protect byte not loaded at reset");
    AST_KEY_UNLOCK: assert property (s_key_finish_ok |-> ##2
        option_working_reg[1:0] == `FSC_UNSECURED_CODE ##1 !mem_secured)
        else $error("good key did not unsecure");
    AST_KEY_DEBUG: assert property ((key_wr_req && debug_access)
        |=> $stable(key_cnt))
        else $error("debug key write was taken");
    AST_KEY_DISABLED: assert property ((key_wr_req
        && !backdoor_key_enable) |=> key_state == $past(key_state))
        else $error("disabled key path moved");
    AST_SECURED: assert property ($changed(option_working_reg[1:0])
        |=> mem_secured == ($past(option_working_reg[1:0])
        != `FSC_UNSECURED_CODE))
        else $error("secured output disagrees with code");
    AST_HIGH_PAGE: assert property (s_setup_low ##1 1'b1
        |-> pready && pslverr)
        else $error("low address not refused");
    AST_KEY_MISMATCH: assert property ((key_state == FSC_KEY_DONE
        && key_bad && !blank_unsec) |=> ##1
        $stable(option_working_reg[1:0]))
        else $error("bad key changed security");
    AST_BLANK: assert property (blank_unsec && !load_pending
        |=> option_working_reg[1:0] == `FSC_UNSECURED_CODE)
        else $error("blank check did not unsecure");
    AST_DIV: assert property ((fclk_tick && clean &&
        !(wr && idx == `FSC_IDX_CLKDIV)) |-> gap == period)
        else $error("timing tick period wrong");
    AST_IRQ: assert property (|(irq_status & irq_mask) |=> irq)
        else $error("interrupt not raised");
endmodule : fsc_top

//--- sim/fsc_flash_model.sv
// Flash array model: nonvolatile bytes, backdoor key, erase and blank check.
`timescale 1ns/1ps
module fsc_flash_model #(
    parameter logic [63:0] KEY = 64'h0123_4567_89ab_cdef
) (
    input  wire logic        pclk,
    input  wire logic        prog_en,
    input  wire logic [7:0]  prog_option,
    input  wire logic        erase_req,
    input  wire logic        blank_req,
    input  wire logic        blank_force,
    output logic      [7:0]  nv_protect_byte,
    output logic      [7:0]  nv_option_byte,
    output logic      [63:0] stored_unlock_key,
    output logic             mass_erase_done,
    output logic             blank_verify_ok
);
    logic erased;

    // The key value is arbitrary; byte 0 sits in the low bits.
    assign stored_unlock_key = KEY;

    // An erased array reads all ones, so protection is lifted too.
    assign nv_protect_byte = erased ? 8'hff : 8'ha5;

    // Blank check passes only on an erased array, unless a scenario
    // asks for a false pass to see that the block still refuses it.
    always_ff @(posedge pclk)
    begin
        mass_erase_done <= erase_req;
        blank_verify_ok <= blank_req & (erased | blank_force);
        if (erase_req)
        begin
            erased <= 1'b1;
            nv_option_byte <= 8'hff;
        end
        else if (prog_en)
        begin
            erased <= 1'b0;
            nv_option_byte <= prog_option;
        end
    end
endmodule : fsc_flash_model

//--- sim/testbench.sv
// Self-checking bench for the flash security and clock control.
`timescale 1ns/1ps
`include "fsc_map.svh"
module testbench;
    import fsc_pkg::*;
    localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
    localparam logic [15:0] A_DIV  = {`FSC_IDX_CLKDIV, 2'b00};
    localparam logic [15:0] A_OPT  = {`FSC_IDX_OPTION, 2'b00};
    localparam logic [15:0] A_CFG  = {`FSC_IDX_CONFIG, 2'b00};
    localparam logic [15:0] A_PROT = {`FSC_IDX_PROTECT, 2'b00};
    localparam logic [15:0] A_STAT = {`FSC_IDX_STATUS, 2'b00};
    localparam logic [15:0] A_CMD  = {`FSC_IDX_COMMAND, 2'b00};
    localparam logic [15:0] A_KEY  = {`FSC_IDX_KEY_DATA, 2'b00};
    localparam logic [15:0] A_IST  = {`FSC_IDX_IRQ_STATUS, 2'b00};
    localparam logic [15:0] A_MSK  = {`FSC_IDX_IRQ_MASK, 2'b00};
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        slverr;
    } fsc_row_type;
    // Plain cases: reserved, low-page and unaligned places must refuse.
    localparam fsc_row_type ROWS [14] = '{
        '{1'b0, A_OPT, 32'h0, 32'h83, 1'b0},
        '{1'b0, A_PROT, 32'h0, 32'ha5, 1'b0},
        '{1'b0, A_STAT, 32'h0, 32'hc0, 1'b0},
        '{1'b1, A_PROT, 32'h5a, 32'h0, 1'b0},
        '{1'b0, A_PROT, 32'h0, 32'h5a, 1'b0},
        '{1'b1, A_OPT, 32'h0, 32'h0, 1'b0},
        '{1'b0, A_OPT, 32'h0, 32'h83, 1'b0},
        '{1'b1, A_CFG, 32'h20, 32'h0, 1'b0},
        '{1'b0, A_CFG, 32'h0, 32'h20, 1'b0},
        '{1'b0, A_DIV, 32'h0, 32'h0, 1'b0},
        '{1'b0, 16'h6088, 32'h0, 32'h0, 1'b1},
        '{1'b0, 16'h0198, 32'h0, 32'h0, 1'b1},
        '{1'b0, 16'h6085, 32'h0, 32'h0, 1'b1},
        '{1'b1, 16'h0198, 32'hff, 32'h0, 1'b1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic from_secure_code, debug_access, mass_erase_done, blank_verify_ok;
    logic irq, mem_secured, fclk_tick, prog_en, erase_req, blank_req;
    logic blank_force;
    logic [7:0] prog_option;
    logic [63:0] stored_unlock_key;
    fsc_byte_type nv_protect_byte, nv_option_byte, protect_working;
    int err_count = 0;
    int cmp_count = 0;

    fsc_top i_fsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nv_protect_byte(nv_protect_byte),
        .nv_option_byte(nv_option_byte),
        .stored_unlock_key(stored_unlock_key),
        .from_secure_code(from_secure_code), .debug_access(debug_access),
        .mass_erase_done(mass_erase_done), .blank_verify_ok(blank_verify_ok),
        .irq(irq), .mem_secured(mem_secured), .fclk_tick(fclk_tick),
        .protect_working(protect_working));

    fsc_flash_model #(.KEY(KEY)) i_fsc_flash_model (.pclk(pclk),
        .prog_en(prog_en), .prog_option(prog_option),
        .erase_req(erase_req), .blank_req(blank_req),
        .blank_force(blank_force), .nv_protect_byte(nv_protect_byte),
        .nv_option_byte(nv_option_byte),
        .stored_unlock_key(stored_unlock_key),
        .mass_erase_done(mass_erase_done), .blank_verify_ok(blank_verify_ok));

    // Free-running bus clock, 10 ns period.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle so a following call never re-drives psel at once.
        @(posedge pclk);
    endtask : apb

    // Programs the option byte, then resets for 16 cycles.
    task automatic reset_with(input logic [7:0] opt);
        presetn <= 1'b0;
        prog_en <= 1'b1;
        prog_option <= opt;
        @(posedge pclk);
        prog_en <= 1'b0;
        repeat (15) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : reset_with

    // Eight key bytes, ascending unless rev asks for the wrong order.
    task automatic send_key(input logic [63:0] k, input logic rev);
        for (int i = 0; i < 8; i++)
            apb(1'b1, A_KEY, {24'h0, k[8*(rev ? 7-i : i) +: 8]});
        repeat (4) @(posedge pclk);
    endtask : send_key

    // Counts cycles between two timing ticks.
    task automatic period_is(input int e);
        int n;
        n = 0;
        do @(posedge pclk); while (fclk_tick !== 1'b1);
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (fclk_tick !== 1'b1);
        chk_word("fclk period", e, n);
    endtask : period_is

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // Main sequence: table first, then the awkward cases.
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        from_secure_code = 1'b0;
        debug_access = 1'b0;
        prog_en = 1'b0;
        prog_option = 8'h0;
        erase_req = 1'b0;
        blank_req = 1'b0;
        blank_force = 1'b0;
        reset_with(8'hbf);
        chk_word("protect out", 32'ha5, {24'h0, protect_working});
        chk_bit("secured", 1'b1, mem_secured);
        foreach (ROWS[i])
        begin
            apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].wdata);
            if (!ROWS[i].wr)
                chk_word("read data", ROWS[i].rdata, rd);
            chk_bit("slave error", ROWS[i].slverr, err);
        end
        // A command before any divider write flags an access error.
        apb(1'b1, A_CMD, 32'h20);
        apb(1'b0, A_STAT, 32'h0);
        chk_word("status", 32'hd0, rd);
        apb(1'b0, A_IST, 32'h0);
        chk_word("irq status", 32'h08, rd);
        chk_bit("irq masked", 1'b0, irq);
        apb(1'b1, A_MSK, 32'h08);
        repeat (2) @(posedge pclk);
        chk_bit("irq", 1'b1, irq);
        apb(1'b1, A_IST, 32'h08);
        apb(1'b1, A_STAT, 32'h10);
        repeat (2) @(posedge pclk);
        chk_bit("irq cleared", 1'b0, irq);
        // Key bytes from debug or from unsecured code must be dropped.
        from_secure_code <= 1'b1;
        debug_access <= 1'b1;
        send_key(KEY, 1'b0);
        from_secure_code <= 1'b0;
        debug_access <= 1'b0;
        send_key(KEY, 1'b0);
        chk_bit("secured", 1'b1, mem_secured);
        apb(1'b0, A_IST, 32'h0);
        chk_word("irq status", 32'h0, rd);
        from_secure_code <= 1'b1;
        send_key(KEY, 1'b1);
        chk_bit("secured", 1'b1, mem_secured);
        apb(1'b0, A_IST, 32'h0);
        chk_word("irq status", 32'h02, rd);
        apb(1'b1, A_IST, 32'h02);
        send_key(KEY, 1'b0);
        chk_bit("secured", 1'b0, mem_secured);
        apb(1'b0, A_OPT, 32'h0);
        chk_word("option", 32'h82, rd);
        apb(1'b0, A_IST, 32'h0);
        chk_word("irq status", 32'h01, rd);
        // Short divider, then one that keeps the pulse at 5.04 us.
        apb(1'b1, A_DIV, 32'h04);
        apb(1'b0, A_DIV, 32'h0);
        chk_word("divider", 32'h84, rd);
        period_is(5);
        apb(1'b1, A_DIV, 32'h7e);
        period_is(504);
        // Key path disabled: only erase followed by blank check unlocks.
        reset_with(8'h03);
        chk_bit("secured", 1'b1, mem_secured);
        apb(1'b1, A_CFG, 32'h20);
        send_key(KEY, 1'b0);
        chk_bit("secured", 1'b1, mem_secured);
        blank_force <= 1'b1;
        blank_req <= 1'b1;
        @(posedge pclk);
        blank_req <= 1'b0;
        blank_force <= 1'b0;
        repeat (4) @(posedge pclk);
        chk_bit("secured", 1'b1, mem_secured);
        erase_req <= 1'b1;
        @(posedge pclk);
        erase_req <= 1'b0;
        repeat (3) @(posedge pclk);
        blank_req <= 1'b1;
        @(posedge pclk);
        blank_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk_bit("secured", 1'b0, mem_secured);
        apb(1'b0, A_IST, 32'h0);
        chk_word("irq status", 32'h04, rd);
        // Every security code after reset; only 1:0 leaves memory open.
        for (int c = 0; c < 4; c++)
        begin
            reset_with({6'h20, c[1:0]});
            chk_bit("secured", c != 2, mem_secured);
        end
        print_verdict();
    end

    // Watchdog: the whole run needs well under 5000 cycles.
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("CHECK FAILED watchdog expected done seen hang");
        print_verdict();
    end
endmodule : testbench
